/* hdl/ccrb_coef_mem.sv */
`timescale 1ns/10ps
module ccrb_coef_mem #(
    parameter int unsigned DEPTH = 48,
    parameter int unsigned WIDTH = 27,
    parameter int unsigned AW = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    input wire logic rd_clear,
    output logic [WIDTH-1:0] rd_data_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Contents not loaded since reset read as zero
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data_q <= '0;
        end
        else if (rd_clear)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule : ccrb_coef_mem

/* hdl/ccrb_pkg.sv */
package ccrb_pkg;

    // Register addresses carried by the address word
    localparam logic [15:0] CCRB_ADDR_FILT = 16'h0001;
    localparam logic [15:0] CCRB_ADDR_PWR = 16'h0002;

    // Reset values
    localparam logic [15:0] CCRB_FILT_RST = 16'h001A;
    localparam logic [15:0] CCRB_PWR_RST = 16'h009B;

    // Filter control fields
    localparam int unsigned CCRB_FC_ARM = 15;
    localparam int unsigned CCRB_FC_THR = 14;
    localparam int unsigned CCRB_FC_GAIN = 13;
    localparam int unsigned CCRB_FC_OFF = 12;
    localparam int unsigned CCRB_FC_STAT = 11;
    localparam int unsigned CCRB_FC_ALIGN = 9;
    localparam int unsigned CCRB_FC_TAP_LSB = 5;
    localparam int unsigned CCRB_FC_TAP_MSB = 8;
    localparam int unsigned CCRB_FC_THIRD = 4;
    localparam int unsigned CCRB_FC_FIRST = 3;
    localparam int unsigned CCRB_FC_RATIO_MSB = 2;
    localparam int unsigned CCRB_FC_KEEP_MSB = 8;

    // Power and clock control fields
    localparam int unsigned CCRB_PC_HALF = 5;
    localparam int unsigned CCRB_PC_SHUT = 3;
    localparam int unsigned CCRB_PC_LOWP = 2;
    localparam int unsigned CCRB_PC_AMP = 0;

    // Status word fields driven by this block
    localparam int unsigned CCRB_ST_ZERO = 10;
    localparam int unsigned CCRB_ST_LOWP = 9;
    localparam int unsigned CCRB_ST_DLOK = 7;
    localparam int unsigned CCRB_ST_THIRD = 4;
    localparam int unsigned CCRB_ST_FIRST = 3;

    // Coefficient download
    localparam logic [5:0] CCRB_COEF_MAX = 6'h30;
    localparam logic [5:0] CCRB_COEF_STEP = 6'h03;
    localparam int unsigned CCRB_COEF_W = 27;
    localparam int unsigned CCRB_HI_W = 11;

    typedef enum logic [2:0] {
        CCRB_DL_IDLE = 3'h0,
        CCRB_DL_HIGH = 3'h1,
        CCRB_DL_LOW = 3'h3,
        CCRB_DL_CSUM = 3'h2,
        CCRB_DL_FILL = 3'h6
    } ccrb_dl_state_t;

    typedef enum logic [2:0] {
        CCRB_RS_CONV = 3'h0,
        CCRB_RS_THR = 3'h1,
        CCRB_RS_GAIN = 3'h2,
        CCRB_RS_OFF = 3'h3,
        CCRB_RS_STAT = 3'h4
    } ccrb_rsel_t;

    // Coefficients held for a tap count code
    function automatic logic [5:0] ccrb_coef_count(input logic [3:0] code);
        ccrb_coef_count = ({2'h0, code} + 6'h01) * CCRB_COEF_STEP;
    endfunction : ccrb_coef_count

    // Sum of the two bytes of a word
    function automatic logic [15:0] ccrb_byte_sum(input logic [15:0] w);
        ccrb_byte_sum = {8'h00, w[15:8]} + {8'h00, w[7:0]};
    endfunction : ccrb_byte_sum

endpackage : ccrb_pkg

/* hdl/ccrb_top.sv */
`timescale 1ns/10ps
module ccrb_top
    import ccrb_pkg::*;
#(
    parameter int unsigned DATA_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Host word port
    input wire logic wr_valid,
    input wire logic [15:0] wr_word,
    input wire logic rd_req,
    output logic rd_valid_q,
    output logic [DATA_W-1:0] rd_data_q,
    // Words from neighbouring registers and datapath
    input wire logic [DATA_W-1:0] conv_word,
    input wire logic [15:0] thr_word,
    input wire logic [15:0] gain_word,
    input wire logic [15:0] off_word,
    input wire logic [15:0] status_ext,
    // Filter configuration
    output logic third_stage_enable,
    output logic first_stage_enable,
    output logic [2:0] second_stage_ratio,
    output logic [3:0] tap_count_code,
    output logic filter_align_q,
    // Power and clock configuration
    output logic clock_halving,
    output logic shutdown,
    output logic reduced_power,
    output logic amplifier_shutdown,
    // Coefficient download
    output logic download_active_q,
    output logic download_success_q,
    output logic user_loaded_q,
    input wire logic [5:0] coeff_rd_addr,
    output logic [CCRB_COEF_W-1:0] coeff_rd_data
);

    logic phase_q;
    logic [15:0] addr_q;
    logic [CCRB_FC_KEEP_MSB:0] fc_q;
    logic [15:0] pc_q;
    ccrb_rsel_t rsel_q;
    ccrb_dl_state_t state_q;
    logic [5:0] idx_q;
    logic [5:0] count_q;
    logic [15:0] csum_q;
    logic [CCRB_HI_W-1:0] hi_q;
    logic data_wr;
    logic filt_wr;
    logic pwr_wr;
    logic arm_ok;
    logic mem_we;
    logic [CCRB_COEF_W-1:0] mem_wdata;
    logic [15:0] status_word;

    // Host words are decoded only outside a download
    assign data_wr = wr_valid && phase_q && (state_q == CCRB_DL_IDLE);
    assign filt_wr = data_wr && (addr_q == CCRB_ADDR_FILT);
    assign pwr_wr = data_wr && (addr_q == CCRB_ADDR_PWR);
    assign arm_ok = wr_word[CCRB_FC_ARM] && (wr_word[CCRB_FC_TAP_MSB:CCRB_FC_TAP_LSB] != 4'h0);

    // Address word then data word
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= 1'b0;
            addr_q <= 16'h0000;
        end
        else if (wr_valid && (state_q == CCRB_DL_IDLE))
        begin
            if (!phase_q)
            begin
                addr_q <= wr_word;
            end
            phase_q <= !phase_q;
        end
    end

    // Filter control; bits 15 to 9 are not stored
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fc_q <= CCRB_FILT_RST[CCRB_FC_KEEP_MSB:0];
        end
        else if (filt_wr)
        begin
            fc_q <= wr_word[CCRB_FC_KEEP_MSB:0];
        end
    end

    // Power and clock control
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_q <= CCRB_PWR_RST;
        end
        else if (pwr_wr)
        begin
            pc_q <= wr_word;
        end
    end

    assign third_stage_enable = fc_q[CCRB_FC_THIRD];
    assign first_stage_enable = fc_q[CCRB_FC_FIRST];
    assign second_stage_ratio = fc_q[CCRB_FC_RATIO_MSB:0];
    assign tap_count_code = fc_q[CCRB_FC_TAP_MSB:CCRB_FC_TAP_LSB];
    assign clock_halving = pc_q[CCRB_PC_HALF];
    assign shutdown = pc_q[CCRB_PC_SHUT];
    assign reduced_power = pc_q[CCRB_PC_LOWP];
    assign amplifier_shutdown = pc_q[CCRB_PC_AMP];

    // One-cycle synchronisation start
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filter_align_q <= 1'b0;
        end
        else
        begin
            filter_align_q <= filt_wr && wr_word[CCRB_FC_ALIGN];
        end
    end

    // Readback selection, consumed by the next read
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsel_q <= CCRB_RS_CONV;
        end
        else if (filt_wr && wr_word[CCRB_FC_THR])
        begin
            rsel_q <= CCRB_RS_THR;
        end
        else if (filt_wr && wr_word[CCRB_FC_GAIN])
        begin
            rsel_q <= CCRB_RS_GAIN;
        end
        else if (filt_wr && wr_word[CCRB_FC_OFF])
        begin
            rsel_q <= CCRB_RS_OFF;
        end
        else if (filt_wr && wr_word[CCRB_FC_STAT])
        begin
            rsel_q <= CCRB_RS_STAT;
        end
        else if (rd_req)
        begin
            rsel_q <= CCRB_RS_CONV;
        end
    end

    always_comb
    begin
        status_word = status_ext;
        status_word[CCRB_ST_ZERO] = 1'b0;
        status_word[CCRB_ST_LOWP] = pc_q[CCRB_PC_LOWP];
        status_word[CCRB_ST_DLOK] = download_success_q;
        status_word[CCRB_ST_THIRD] = !fc_q[CCRB_FC_THIRD];
        status_word[CCRB_ST_FIRST] = !fc_q[CCRB_FC_FIRST];
        status_word[CCRB_FC_RATIO_MSB:0] = fc_q[CCRB_FC_RATIO_MSB:0];
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end
        else
        begin
            rd_valid_q <= rd_req;
            if (rd_req)
            begin
                case (rsel_q)
                    CCRB_RS_THR: rd_data_q <= DATA_W'(thr_word);
                    CCRB_RS_GAIN: rd_data_q <= DATA_W'(gain_word);
                    CCRB_RS_OFF: rd_data_q <= DATA_W'(off_word);
                    CCRB_RS_STAT: rd_data_q <= DATA_W'(status_word);
                    default: rd_data_q <= conv_word;
                endcase
            end
        end
    end

    // Coefficient download sequence
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= CCRB_DL_IDLE;
            idx_q <= 6'h00;
            count_q <= 6'h00;
            csum_q <= 16'h0000;
            hi_q <= '0;
        end
        else
        begin
            case (state_q)
                CCRB_DL_IDLE:
                begin
                    if (filt_wr && arm_ok)
                    begin
                        state_q <= CCRB_DL_HIGH;
                        count_q <= ccrb_coef_count(wr_word[CCRB_FC_TAP_MSB:CCRB_FC_TAP_LSB]);
                        idx_q <= 6'h00;
                        csum_q <= 16'h0000;
                    end
                end
                CCRB_DL_HIGH:
                begin
                    if (wr_valid)
                    begin
                        hi_q <= wr_word[CCRB_HI_W-1:0];
                        csum_q <= csum_q + ccrb_byte_sum(wr_word);
                        state_q <= CCRB_DL_LOW;
                    end
                end
                CCRB_DL_LOW:
                begin
                    if (wr_valid)
                    begin
                        csum_q <= csum_q + ccrb_byte_sum(wr_word);
                        idx_q <= idx_q + 6'h01;
                        if ((idx_q + 6'h01) == count_q)
                        begin
                            state_q <= CCRB_DL_CSUM;
                        end
                        else
                        begin
                            state_q <= CCRB_DL_HIGH;
                        end
                    end
                end
                CCRB_DL_CSUM:
                begin
                    if (wr_valid)
                    begin
                        if (idx_q == CCRB_COEF_MAX)
                        begin
                            state_q <= CCRB_DL_IDLE;
                        end
                        else
                        begin
                            state_q <= CCRB_DL_FILL;
                        end
                    end
                end
                CCRB_DL_FILL:
                begin
                    idx_q <= idx_q + 6'h01;
                    if (idx_q == (CCRB_COEF_MAX - 6'h01))
                    begin
                        state_q <= CCRB_DL_IDLE;
                    end
                end
                default:
                begin
                    state_q <= CCRB_DL_IDLE;
                end
            endcase
        end
    end

    // Checksum result and user filter presence
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            download_success_q <= 1'b0;
            user_loaded_q <= 1'b0;
        end
        else if ((state_q == CCRB_DL_CSUM) && wr_valid)
        begin
            download_success_q <= (wr_word == csum_q);
            user_loaded_q <= 1'b1;
        end
        else if (filt_wr && arm_ok)
        begin
            download_success_q <= 1'b0;
            user_loaded_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            download_active_q <= 1'b0;
        end
        else
        begin
            download_active_q <= (filt_wr && arm_ok)
                || ((state_q != CCRB_DL_IDLE)
                && !((state_q == CCRB_DL_CSUM) && wr_valid && (idx_q == CCRB_COEF_MAX))
                && !((state_q == CCRB_DL_FILL) && (idx_q == (CCRB_COEF_MAX - 6'h01))));
        end
    end

    // Unused taps are written with zero after the checksum
    assign mem_we = ((state_q == CCRB_DL_LOW) && wr_valid) || (state_q == CCRB_DL_FILL);
    assign mem_wdata = (state_q == CCRB_DL_FILL) ? '0 : {hi_q, wr_word};

    ccrb_coef_mem #(
        .DEPTH(48),
        .WIDTH(CCRB_COEF_W),
        .AW(6)
    ) u_coef_mem (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_en(mem_we),
        .wr_addr(idx_q),
        .wr_data(mem_wdata),
        .rd_addr(coeff_rd_addr),
        .rd_clear(!user_loaded_q),
        .rd_data_q(coeff_rd_data)
    );

    // Checks
    logic seen_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seen_q <= 1'b0;
        end
        else
        begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_WR_APPLY: assert property (
        filt_wr |=> second_stage_ratio == $past(wr_word[2:0]) && !phase_q)
        else $error("filter control data word not applied");

    AST_RESET_VAL: assert property (
        !seen_q |-> (fc_q == CCRB_FILT_RST[CCRB_FC_KEEP_MSB:0]) && (pc_q == CCRB_PWR_RST))
        else $error("reset values wrong");

    AST_ARM_ENTERS: assert property (
        (filt_wr && arm_ok) |=> (state_q == CCRB_DL_HIGH) ##1 !phase_q)
        else $error("arm did not start download");

    AST_THR_READ: assert property (
        (rd_req && rsel_q == CCRB_RS_THR) |=> rd_valid_q && rd_data_q == $past(thr_word))
        else $error("threshold readback wrong");

    AST_GAIN_READ: assert property (
        (rd_req && rsel_q == CCRB_RS_GAIN) |=> rd_valid_q && rd_data_q == $past(gain_word))
        else $error("gain readback wrong");

    AST_OFF_READ: assert property (
        (rd_req && rsel_q == CCRB_RS_OFF) |=> rd_data_q == $past(off_word))
        else $error("offset readback wrong");

    AST_STAT_READ: assert property (
        (rd_req && rsel_q == CCRB_RS_STAT) |=> rd_data_q[CCRB_ST_DLOK] == $past(download_success_q))
        else $error("status readback wrong");

    AST_ALIGN_PULSE: assert property (
        (filt_wr && wr_word[CCRB_FC_ALIGN]) |=> filter_align_q ##1 !filter_align_q)
        else $error("align pulse not one cycle");

    AST_CSUM_CHECK: assert property (
        (state_q == CCRB_DL_CSUM && wr_valid) |=> download_success_q == ($past(wr_word) == $past(csum_q)))
        else $error("checksum compare wrong");

    AST_ONE_SHOT_SEL: assert property (
        (rd_req && !filt_wr) ##1 !filt_wr ##1 (rd_req && !filt_wr)
        |=> rd_data_q == $past(conv_word))
        else $error("selection applied to more than one read");

    AST_VOLATILE: assert property (
        !user_loaded_q |=> coeff_rd_data == '0)
        else $error("coefficients visible before download");

    COV_DOWNLOAD: cover property ((state_q == CCRB_DL_CSUM && wr_valid) ##1 download_success_q);
    COV_STATUS: cover property (rd_req && rsel_q == CCRB_RS_STAT);
    COV_ALIGN: cover property (filter_align_q);
    COV_FULL: cover property ((state_q == CCRB_DL_FILL) ##[1:60] (state_q == CCRB_DL_IDLE));

endmodule : ccrb_top

/* testbench/ccrb_host_model.sv */
`timescale 1ns/10ps
module ccrb_host_model
    import ccrb_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Word and read strobes
    output logic wr_valid,
    output logic [15:0] wr_word,
    output logic rd_req,
    // Read answer
    input wire logic rd_valid_q,
    input wire logic [15:0] rd_data_q
);
    initial
    begin
        wr_valid = 1'b0;
        wr_word = 16'h0000;
        rd_req = 1'b0;
    end

    task automatic send_word(input logic [15:0] w);
        wr_valid = 1'b1;
        wr_word = w;
        @(posedge clk_sys);
        #1;
    endtask : send_word

    // Released lines show the inverse of the last word
    task automatic idle();
        wr_valid = 1'b0;
        wr_word = ~wr_word;
        @(posedge clk_sys);
        #1;
    endtask : idle

    task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
        send_word(a);
        send_word(d);
        idle();
    endtask : write_reg

    // Caller sets one select bit at most; bit 10 forced low
    task automatic write_fc(input logic [15:0] d);
        write_reg(CCRB_ADDR_FILT, d & 16'hFBFF);
    endtask : write_fc

    task automatic write_pc(input logic [15:0] d);
        write_reg(CCRB_ADDR_PWR, d | 16'h0002);
    endtask : write_pc

    task automatic download(input logic [3:0] tap, input logic [2:0] ratio,
                            input logic [26:0] c [$], input logic bad);
        logic [15:0] sum;
        logic [15:0] w1;
        logic [15:0] w2;
        write_fc({1'b1, 6'h00, tap, 2'b11, ratio});
        sum = 16'h0000;
        for (int i = 0; i < 3 * (tap + 1); i++)
        begin
            w1 = {5'h00, c[i][26:16]};
            w2 = c[i][15:0];
            send_word(w1);
            send_word(w2);
            sum = sum + w1[15:8] + w1[7:0] + w2[15:8] + w2[7:0];
        end
        send_word(bad ? ~sum : sum);
        idle();
    endtask : download

    // Answer stands for one cycle after the request edge
    task automatic read_word(output logic [15:0] d, output logic v);
        rd_req = 1'b1;
        @(posedge clk_sys);
        #1;
        v = rd_valid_q;
        d = rd_data_q;
        rd_req = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : read_word
endmodule : ccrb_host_model

/* testbench/converter_control_register_bank_test.sv */
`timescale 1ns/10ps
module converter_control_register_bank_test;
    import ccrb_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic wr_valid, rd_req, rd_valid_q, third_stage_enable, first_stage_enable;
    logic filter_align_q, clock_halving, shutdown, reduced_power, amplifier_shutdown;
    logic download_active_q, download_success_q, user_loaded_q;
    logic [15:0] wr_word, rd_data_q;
    logic [15:0] conv_word = 16'h1234;
    logic [15:0] thr_word = 16'hCCCC;
    logic [15:0] gain_word = 16'hA000;
    logic [15:0] off_word = 16'h0000;
    logic [15:0] status_ext = 16'h0000;
    logic [2:0] second_stage_ratio;
    logic [3:0] tap_count_code;
    logic [5:0] coeff_rd_addr = 6'h00;
    logic [CCRB_COEF_W-1:0] coeff_rd_data;
    integer seed = 99500;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_align = 0;
    int e_align = 0;
    logic [15:0] m_fc, m_pc, d, rv;
    logic [15:0] sw [4];
    logic m_ok, v;
    logic [26:0] cq [$];
    wire logic [8:0] fc_seen = {tap_count_code, third_stage_enable, first_stage_enable,
                                second_stage_ratio};
    wire logic [5:0] pc_seen = {clock_halving, 1'b0, shutdown, reduced_power, 1'b0,
                                amplifier_shutdown};

    always #20 clk_sys = ~clk_sys;

    ccrb_top dut (.clk_sys, .arst_n, .wr_valid, .wr_word, .rd_req, .rd_valid_q, .rd_data_q,
        .conv_word, .thr_word, .gain_word, .off_word, .status_ext, .third_stage_enable,
        .first_stage_enable, .second_stage_ratio, .tap_count_code, .filter_align_q,
        .clock_halving, .shutdown, .reduced_power, .amplifier_shutdown, .download_active_q,
        .download_success_q, .user_loaded_q, .coeff_rd_addr, .coeff_rd_data);

    ccrb_host_model host (.clk_sys, .wr_valid, .wr_word, .rd_req, .rd_valid_q, .rd_data_q);

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // Align pulses counted; cycle ceiling cuts a hang
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (filter_align_q === 1'b1)
            n_align <= n_align + 1;
        if (cyc == 6000)
        begin
            fails = fails + 1;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk

    task automatic check_cfg();
        @(posedge clk_sys);
        #1;
        chk("filter fields", fc_seen, m_fc[8:0]);
        chk("power fields", pc_seen, m_pc[5:0] & 6'h2D);
        chk("download ok", download_success_q, m_ok);
        chk("align pulses", n_align, e_align);
    endtask : check_cfg

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        m_fc = 16'h001A;
        m_pc = 16'h009B;
        m_ok = 1'b0;
    endtask : do_reset

    task automatic do_read(input logic [15:0] e, input string nm);
        host.read_word(rv, v);
        chk("read valid", v, 1'b1);
        chk(nm, rv, e);
    endtask : do_read

    function automatic logic [15:0] st_exp(input logic [15:0] s);
        st_exp = (s & 16'hF960) | {6'h00, m_pc[2], 1'b0, m_ok, 2'b00, ~m_fc[4], ~m_fc[3],
                                   m_fc[2:0]};
    endfunction : st_exp

    initial
    begin
        do_reset();
        check_cfg();
        do_read(conv_word, "plain read");
        host.write_pc(16'h0002);
        m_pc = 16'h0002;
        check_cfg();
        $display("test reset done");
        for (int i = 0; i < 30; i++)
        begin
            d = $random(seed) & 16'h03FF;
            d[2:0] = d[2:0] % 3'h6;
            host.write_fc(d);
            m_fc[8:0] = d[8:0];
            e_align += d[9];
            d = $random(seed);
            host.write_pc(d);
            m_pc = d | 16'h0002;
            host.write_reg(16'h0003, ~d);
            check_cfg();
        end
        $display("test config done");
        for (int k = 0; k < 4; k++)
        begin
            conv_word = $random(seed);
            thr_word = $random(seed);
            gain_word = $random(seed);
            off_word = $random(seed);
            status_ext = $random(seed);
            sw = '{thr_word, gain_word, off_word, st_exp(status_ext)};
            host.write_fc((16'h4000 >> k) | m_fc[8:0]);
            do_read(sw[k], "selected read");
            do_read(conv_word, "next read");
        end
        $display("test readback done");
        for (int k = 0; k < 2; k++)
        begin
            cq = {};
            for (int i = 0; i < 12; i++)
                cq.push_back(27'($random(seed)));
            host.download(4'h3 - 4'(2 * k), 3'h4, cq, k == 0);
            m_fc[8:0] = {4'h3 - 4'(2 * k), 5'h1C};
            m_ok = (k == 1);
            chk("download active", download_active_q, 1'b1);
            for (int i = 0; i < 200 && download_active_q !== 1'b0; i++)
            begin
                @(posedge clk_sys);
                #1;
            end
            check_cfg();
        end
        for (int i = 0; i < 48; i++)
        begin
            coeff_rd_addr = 6'(i);
            @(posedge clk_sys);
            #1;
            chk("coefficient", coeff_rd_data, i < 6 ? cq[i] : 27'h0);
        end
        chk("user loaded", user_loaded_q, 1'b1);
        $display("test download done");
        do_reset();
        check_cfg();
        chk("user loaded", user_loaded_q, 1'b0);
        coeff_rd_addr = 6'h00;
        @(posedge clk_sys);
        #1;
        chk("coefficient", coeff_rd_data, 27'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule : converter_control_register_bank_test
